// [core/addr_former.sv]
// Purpose: combinational address forming for indexed and vectored modes
// Assumes: base registers come straight from flip-flops
// Notes:   no state
`timescale 1ns/10ps
`default_nettype none

module addr_former
(
  input  wire logic [15:0] indexBase,
  input  wire logic [7:0]  displacement,
  input  wire logic [7:0]  vectorPage,
  input  wire logic [7:0]  vectorLow,
  input  wire logic        tableSecond,
  output logic      [15:0] indexedAddr,
  output logic      [15:0] tableAddr
);

  always_comb
  begin
    // sign extended displacement added to base
    indexedAddr = indexBase + {{8{displacement[7]}}, displacement};
    // page byte over the even peripheral byte, plus one for the high byte
    tableAddr   = {vectorPage, vectorLow[7:1], tableSecond};
  end

endmodule

`default_nettype wire

// [core/cpu_register_array.sv]
// Behaviour
// - 16-bit program counter increments after its value is sent for a fetch.
// - jump, call or return load the target, overriding the increment.
// - stack pointer decrements before each push, increments after each pop.
// - indexed address is index base plus signed displacement byte.
// - vectored pointer is vector page over the peripheral's low byte.
// - low routine byte at even address, high byte at next, then call.
// - sweep count increments after every opcode fetch, shown on low address.
// - instructions can read and load the sweep count.
// - sixteen working bytes in main and alternate sets, one visible.
// - swap_acc_pair exchanges accumulator and status with alternates.
// - swap_main_set exchanges B to L with alternates only.
// - status holds six flags, readable by push only, no direct write.
// - neg, null, parity_ovf and wrap testable; others internal only.
// - wrap set by add carry out of bit 7 or subtract borrow.
// - set_wrap_op forces wrap, flip_wrap_op inverts it.
// - logic clears wrap; listed arithmetic updates it; others keep it.
// - sub_mark set by subtracts, decrements, complement, block I/O, searches, negate.
// - sub_mark cleared by adds, increments, logic, rotates and listed others.
// - decimal fix picks correction from sub_mark and nibble_wrap.
// - accumulator takes every 8-bit alu result and serves data moves.
// - refresh strobe low one cycle after the third and fourth fetch states, with sweep count.
//
// Purpose: register array of an 8-bit core
// Assumes: decoder sequences the steps and honours the even vector byte
// Notes:   all outputs registered
`timescale 1ns/10ps
`default_nettype none
`include "cpu_regs_params.svh"

module cpu_register_array
(
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire cpu_regs_pkg::pc_op_e         pcOp,
  input  wire logic                  [15:0] pcTarget,
  input  wire logic                         pushByte,
  input  wire logic                         popByte,
  input  wire logic                         spLoad,
  input  wire logic                  [15:0] spValue,
  input  wire logic                         idxFirstLoad,
  input  wire logic                         idxSecondLoad,
  input  wire logic                  [15:0] idxValue,
  input  wire logic                         idxSelSecond,
  input  wire logic                  [7:0]  displacement,
  input  wire logic                         vectorPageLoad,
  input  wire logic                         sweepLoad,
  input  wire logic                  [7:0]  specValue,
  input  wire logic                  [7:0]  vectorLow,
  input  wire logic                         tableSecond,
  input  wire logic                         fetchDone,
  input  wire logic                  [1:0]  fetchState,
  input  wire logic                         fetchCycle,
  input  wire logic                         workWrite,
  input  wire cpu_regs_pkg::work_sel_e      workSel,
  input  wire logic                  [7:0]  workValue,
  input  wire logic                         aluWrite,
  input  wire logic                  [7:0]  aluResult,
  input  wire cpu_regs_pkg::flag_op_e       flagOp,
  input  wire logic                         aluCarry,
  input  wire logic                  [7:0]  aluFlags,
  input  wire logic                         swapAccPair,
  input  wire logic                         swapMainSet,
  output logic                       [15:0] programCounter,
  output logic                       [15:0] stackPointer,
  output logic                       [15:0] indexFirst,
  output logic                       [15:0] indexSecond,
  output logic                       [7:0]  vectorPage,
  output logic                       [7:0]  sweepCount,
  output logic                       [15:0] indexedAddr,
  output logic                       [15:0] tableAddr,
  output logic                       [7:0]  accumulator,
  output logic                       [7:0]  statusBits,
  output logic                       [7:0]  workRead,
  output logic                       [3:0]  testFlags,
  output logic                       [7:0]  refreshAddr,
  output logic                              refreshStrobe_n
);

  // visible and alternate sets: index 0..5 = B..L, 6 = acc, 7 = status
  logic [7:0] mainSet [0:7];
  logic [7:0] altSet  [0:7];
  logic [7:0] next_mainSet [0:7];
  logic [7:0] next_altSet  [0:7];
  logic [15:0] next_programCounter;
  logic [15:0] next_stackPointer;
  logic [15:0] next_indexFirst;
  logic [15:0] next_indexSecond;
  logic [7:0]  next_vectorPage;
  logic [7:0]  next_sweepCount;
  logic [15:0] next_indexedAddr;
  logic [15:0] next_tableAddr;
  logic [7:0]  next_workRead;
  logic        next_refreshStrobe_n;
  logic [7:0]  statusNext;
  logic [15:0] idxAddrComb;
  logic [15:0] tblAddrComb;

  function automatic logic [2:0] sel_index(input cpu_regs_pkg::work_sel_e s);
    sel_index = (s == cpu_regs_pkg::WR_ACC) ? 3'h6 : s;
  endfunction

  flag_unit u_flag
  (
    .statusNow  (mainSet[7]),
    .flagOp     (flagOp),
    .aluCarry   (aluCarry),
    .aluFlags   (aluFlags),
    .statusNext (statusNext)
  );

  addr_former u_addr
  (
    .indexBase    (idxSelSecond ? indexSecond : indexFirst),
    .displacement (displacement),
    .vectorPage   (vectorPage),
    .vectorLow    (vectorLow),
    .tableSecond  (tableSecond),
    .indexedAddr  (idxAddrComb),
    .tableAddr    (tblAddrComb)
  );

  // dedicated registers
  always_comb
  begin
    next_programCounter = programCounter;
    unique case (pcOp)
      cpu_regs_pkg::PC_LOAD: next_programCounter = pcTarget;
      cpu_regs_pkg::PC_INC:  next_programCounter = programCounter + 16'h0001;
      default:               next_programCounter = programCounter;
    endcase
    next_stackPointer = stackPointer;
    if (spLoad)
    begin
      next_stackPointer = spValue;
    end
    else if (pushByte)
    begin
      next_stackPointer = stackPointer - 16'h0001;
    end
    else if (popByte)
    begin
      next_stackPointer = stackPointer + 16'h0001;
    end
    next_indexFirst  = idxFirstLoad ? idxValue : indexFirst;
    next_indexSecond = idxSecondLoad ? idxValue : indexSecond;
    next_vectorPage  = vectorPageLoad ? specValue : vectorPage;
    if (sweepLoad)
    begin
      next_sweepCount = specValue;
    end
    else if (fetchDone)
    begin
      next_sweepCount = sweepCount + 8'h01;
    end
    else
    begin
      next_sweepCount = sweepCount;
    end
    next_indexedAddr = idxAddrComb;
    next_tableAddr   = tblAddrComb;
    // low in states 3 and 4 (codes 2 and 3) of a fetch
    next_refreshStrobe_n = ~(fetchCycle & fetchState[1]);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      programCounter  <= `RST_WORD;
      stackPointer    <= `RST_STACK;
      indexFirst      <= `RST_WORD;
      indexSecond     <= `RST_WORD;
      vectorPage      <= `RST_BYTE;
      sweepCount      <= `RST_BYTE;
      indexedAddr     <= `RST_WORD;
      tableAddr       <= `RST_WORD;
      refreshStrobe_n <= 1'b1;
    end
    else
    begin
      programCounter  <= next_programCounter;
      stackPointer    <= next_stackPointer;
      indexFirst      <= next_indexFirst;
      indexSecond     <= next_indexSecond;
      vectorPage      <= next_vectorPage;
      sweepCount      <= next_sweepCount;
      indexedAddr     <= next_indexedAddr;
      tableAddr       <= next_tableAddr;
      refreshStrobe_n <= next_refreshStrobe_n;
    end
  end

  // working sets
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      next_mainSet[i] = mainSet[i];
      next_altSet[i]  = altSet[i];
    end
    if (workWrite && workSel != cpu_regs_pkg::WR_ACC)
    begin
      next_mainSet[sel_index(workSel)] = workValue;
    end
    if (workWrite && workSel == cpu_regs_pkg::WR_ACC)
    begin
      next_mainSet[6] = workValue;
    end
    if (aluWrite)
    begin
      next_mainSet[6] = aluResult;
    end
    // status has no direct write path
    next_mainSet[7] = statusNext & `ST_USED_MASK;
    if (swapAccPair)
    begin
      next_mainSet[6] = altSet[6];
      next_mainSet[7] = altSet[7];
      next_altSet[6]  = mainSet[6];
      next_altSet[7]  = mainSet[7];
    end
    if (swapMainSet)
    begin
      for (int i = 0; i < 6; i++)
      begin
        next_mainSet[i] = altSet[i];
        next_altSet[i]  = mainSet[i];
      end
    end
    next_workRead = mainSet[sel_index(workSel)];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 8; i++)
      begin
        mainSet[i] <= `RST_BYTE;
        altSet[i]  <= `RST_BYTE;
      end
      workRead <= `RST_BYTE;
    end
    else
    begin
      for (int i = 0; i < 8; i++)
      begin
        mainSet[i] <= next_mainSet[i];
        altSet[i]  <= next_altSet[i];
      end
      workRead <= next_workRead;
    end
  end

  // registered copies of visible state
  always_comb
  begin
    accumulator = mainSet[6];
    statusBits  = mainSet[7];
    refreshAddr = sweepCount;
    testFlags   = {mainSet[7][`ST_NEG_BIT], mainSet[7][`ST_NULL_BIT],
                   mainSet[7][`ST_PARITY_OVF], mainSet[7][`ST_WRAP_BIT]};
  end

  property p_pc_inc;
    @(posedge clk) disable iff (!rst_n)
      pcOp == cpu_regs_pkg::PC_INC |=> programCounter == $past(programCounter) + 16'h0001;
  endproperty
  a_pc_inc: assert property (p_pc_inc) else $error("pc increment wrong");

  property p_pc_load;
    @(posedge clk) disable iff (!rst_n)
      pcOp == cpu_regs_pkg::PC_LOAD |=> programCounter == $past(pcTarget);
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("pc load wrong");

  property p_sp_push;
    @(posedge clk) disable iff (!rst_n)
      pushByte && !spLoad |=> stackPointer == $past(stackPointer) - 16'h0001;
  endproperty
  a_sp_push: assert property (p_sp_push) else $error("push decrement wrong");

  property p_indexed;
    @(posedge clk) disable iff (!rst_n)
      !idxSelSecond && $stable(indexFirst) |=>
        indexedAddr == $past(indexFirst) + {{8{$past(displacement[7])}}, $past(displacement)};
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");

  property p_table;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |=> tableAddr[15:8] == $past(vectorPage) && tableAddr[0] == $past(tableSecond);
  endproperty
  a_table: assert property (p_table) else $error("table pointer wrong");

  property p_sweep;
    @(posedge clk) disable iff (!rst_n)
      fetchDone && !sweepLoad |=> sweepCount == $past(sweepCount) + 8'h01;
  endproperty
  a_sweep: assert property (p_sweep) else $error("sweep count wrong");

  property p_swap_acc;
    @(posedge clk) disable iff (!rst_n)
      swapAccPair ##1 swapAccPair |=> accumulator == $past(accumulator, 2);
  endproperty
  a_swap_acc: assert property (p_swap_acc) else $error("double swap lost value");

  property p_set_wrap;
    @(posedge clk) disable iff (!rst_n)
      flagOp == cpu_regs_pkg::OP_SET_WRAP && !swapAccPair |=>
        statusBits[`ST_WRAP_BIT] && !statusBits[`ST_SUB_MARK];
  endproperty
  a_set_wrap: assert property (p_set_wrap) else $error("set wrap failed");

  property p_logic_clear;
    @(posedge clk) disable iff (!rst_n)
      flagOp == cpu_regs_pkg::OP_LOGIC && !swapAccPair |=> !statusBits[`ST_WRAP_BIT];
  endproperty
  a_logic_clear: assert property (p_logic_clear) else $error("logic kept wrap");

  property p_refresh;
    @(posedge clk) disable iff (!rst_n)
      fetchCycle && fetchState[1] |=> !refreshStrobe_n;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh strobe missing");

endmodule

`default_nettype wire

// [core/cpu_regs_params.svh]
// Purpose: constants for the cpu register array
// Assumes: 8-bit core, single clock
// Notes:   field positions of the status byte and reset values
`ifndef CPU_REGS_PARAMS_SVH
`define CPU_REGS_PARAMS_SVH

`define ST_NEG_BIT      7
`define ST_NULL_BIT     6
`define ST_NIBBLE_WRAP  4
`define ST_PARITY_OVF   2
`define ST_SUB_MARK     1
`define ST_WRAP_BIT     0
`define ST_USED_MASK    8'hd7
`define RST_WORD        16'h0000
`define RST_BYTE        8'h00
`define RST_STACK       16'hffff

`endif

// [core/cpu_regs_pkg.sv]
// Purpose: types shared by the register array files
// Assumes: nothing beyond the params header
// Notes:   operation classes decide the carry and add/subtract flag update
package cpu_regs_pkg;

  // flag update class chosen by the decoder
  typedef enum logic [3:0]
  {
    OP_NONE     = 4'b0000,
    OP_ADD      = 4'b0001,
    OP_SUB      = 4'b0010,
    OP_LOGIC    = 4'b0011,
    OP_ROT_ACC  = 4'b0100,
    OP_ROT      = 4'b0101,
    OP_DEC_FIX  = 4'b0110,
    OP_NEG      = 4'b0111,
    OP_SET_WRAP = 4'b1000,
    OP_FLIP     = 4'b1001,
    OP_INC      = 4'b1010,
    OP_DEC8     = 4'b1011,
    OP_CPL      = 4'b1100,
    OP_BLK_SUB  = 4'b1101,
    OP_BLK_CLR  = 4'b1110,
    OP_LD_SPEC  = 4'b1111
  } flag_op_e;

  // selector for one visible 8-bit working register
  typedef enum logic [2:0]
  {
    WR_B   = 3'b000,
    WR_C   = 3'b001,
    WR_D   = 3'b010,
    WR_E   = 3'b011,
    WR_H   = 3'b100,
    WR_L   = 3'b101,
    WR_ACC = 3'b111
  } work_sel_e;

  // selector of the program counter source
  typedef enum logic [1:0]
  {
    PC_HOLD = 2'b00,
    PC_INC  = 2'b01,
    PC_LOAD = 2'b10
  } pc_op_e;

endpackage

// [core/flag_unit.sv]
// Purpose: next value of the status byte for wrap_bit and sub_mark
// Assumes: other flags arrive computed from the alu
// Notes:   no state
`timescale 1ns/10ps
`default_nettype none
`include "cpu_regs_params.svh"

module flag_unit
(
  input  wire logic                  [7:0] statusNow,
  input  wire cpu_regs_pkg::flag_op_e      flagOp,
  input  wire logic                        aluCarry,
  input  wire logic                  [7:0] aluFlags,
  output logic                       [7:0] statusNext
);

  logic wrapNow;

  always_comb
  begin
    wrapNow    = statusNow[`ST_WRAP_BIT];
    statusNext = statusNow;
    unique case (flagOp)
      cpu_regs_pkg::OP_NONE:
      begin
        statusNext = statusNow;
      end
      cpu_regs_pkg::OP_ADD, cpu_regs_pkg::OP_INC, cpu_regs_pkg::OP_ROT,
      cpu_regs_pkg::OP_ROT_ACC:
      begin
        statusNext = aluFlags & `ST_USED_MASK;
        statusNext[`ST_SUB_MARK] = 1'b0;
        if (flagOp != cpu_regs_pkg::OP_INC)
        begin
          statusNext[`ST_WRAP_BIT] = aluCarry;
        end
        else
        begin
          statusNext[`ST_WRAP_BIT] = wrapNow;
        end
      end
      cpu_regs_pkg::OP_SUB, cpu_regs_pkg::OP_NEG:
      begin
        statusNext = aluFlags & `ST_USED_MASK;
        statusNext[`ST_SUB_MARK] = 1'b1;
        statusNext[`ST_WRAP_BIT] = aluCarry;  // borrow
      end
      cpu_regs_pkg::OP_LOGIC:
      begin
        statusNext = aluFlags & `ST_USED_MASK;
        statusNext[`ST_SUB_MARK] = 1'b0;
        statusNext[`ST_WRAP_BIT] = 1'b0;
      end
      cpu_regs_pkg::OP_DEC_FIX:
      begin
        // sub_mark kept, alu used it to pick the correction
        statusNext = aluFlags & `ST_USED_MASK;
        statusNext[`ST_SUB_MARK] = statusNow[`ST_SUB_MARK];
        statusNext[`ST_WRAP_BIT] = aluCarry;
      end
      cpu_regs_pkg::OP_SET_WRAP:
      begin
        statusNext[`ST_WRAP_BIT] = 1'b1;
        statusNext[`ST_SUB_MARK] = 1'b0;
      end
      cpu_regs_pkg::OP_FLIP:
      begin
        statusNext[`ST_WRAP_BIT] = ~wrapNow;
        statusNext[`ST_SUB_MARK] = 1'b0;
      end
      cpu_regs_pkg::OP_DEC8, cpu_regs_pkg::OP_CPL, cpu_regs_pkg::OP_BLK_SUB:
      begin
        statusNext = aluFlags & `ST_USED_MASK;
        statusNext[`ST_WRAP_BIT] = wrapNow;
        statusNext[`ST_SUB_MARK] = 1'b1;
      end
      cpu_regs_pkg::OP_BLK_CLR, cpu_regs_pkg::OP_LD_SPEC:
      begin
        statusNext = aluFlags & `ST_USED_MASK;
        statusNext[`ST_WRAP_BIT] = wrapNow;
        statusNext[`ST_SUB_MARK] = 1'b0;
      end
    endcase
  end

endmodule

`default_nettype wire

// [testbench/fetch_model.sv]
// Purpose: far-side stand-in for the decoder timing and the interrupting peripheral
// Assumes: one opcode fetch of four states per go pulse
// Notes:   idle outside fetches, vector byte always even
`timescale 1ns/10ps
`default_nettype none

module fetch_model
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       go,
  input  wire logic [7:0] periphByte,
  output logic            fetchCycle,
  output logic      [1:0] fetchState,
  output logic            fetchDone,
  output logic      [7:0] vectorLow
);
  logic [2:0] step;

  // states one to four of a fetch, then idle
  always @(posedge clk)
  begin
    if (!rst_n)
      step <= 3'h0;
    else if (step != 3'h0)
      step <= (step == 3'h4) ? 3'h0 : step + 3'h1;
    else if (go)
      step <= 3'h1;
  end

  assign fetchCycle = (step != 3'h0);
  assign fetchState = fetchCycle ? 2'(step - 3'h1) : 2'h0;
  assign fetchDone  = (step == 3'h4);
  assign vectorLow  = {periphByte[7:1], 1'b0};
endmodule

`default_nettype wire

// [testbench/tb.sv]
// Purpose: self-checking bench for the register array
// Assumes: fetch_model drives fetch timing and vector byte
// Notes:   all inputs change on the rising edge by non-blocking assignment
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic                    clk, rst_n, pushByte, popByte, spLoad, idxFirstLoad, idxSecondLoad;
  logic                    idxSelSecond, vectorPageLoad, sweepLoad, tableSecond, workWrite;
  logic                    aluWrite, aluCarry, swapAccPair, swapMainSet, go;
  logic                    fetchDone, fetchCycle, refreshStrobe_n;
  logic [1:0]              fetchState;
  logic [3:0]              testFlags;
  logic [7:0]              displacement, specValue, vectorLow, workValue, aluResult, aluFlags;
  logic [7:0]              periphByte, vectorPage, sweepCount, accumulator, statusBits;
  logic [7:0]              workRead, refreshAddr;
  logic [15:0]             pcTarget, spValue, idxValue, programCounter, stackPointer;
  logic [15:0]             indexFirst, indexSecond, indexedAddr, tableAddr;
  cpu_regs_pkg::pc_op_e    pcOp;
  cpu_regs_pkg::work_sel_e workSel;
  cpu_regs_pkg::flag_op_e  flagOp;
  integer                  fails, compares, cycles, i;
  cpu_regs_pkg::work_sel_e sels [6] = '{cpu_regs_pkg::WR_B, cpu_regs_pkg::WR_C,
    cpu_regs_pkg::WR_D, cpu_regs_pkg::WR_E, cpu_regs_pkg::WR_H, cpu_regs_pkg::WR_L};
  cpu_regs_pkg::flag_op_e  ops [17] = '{cpu_regs_pkg::OP_ADD, cpu_regs_pkg::OP_SUB,
    cpu_regs_pkg::OP_SET_WRAP, cpu_regs_pkg::OP_DEC8, cpu_regs_pkg::OP_FLIP,
    cpu_regs_pkg::OP_NONE, cpu_regs_pkg::OP_SUB, cpu_regs_pkg::OP_INC, cpu_regs_pkg::OP_LOGIC,
    cpu_regs_pkg::OP_CPL, cpu_regs_pkg::OP_ROT, cpu_regs_pkg::OP_NEG, cpu_regs_pkg::OP_DEC_FIX,
    cpu_regs_pkg::OP_BLK_CLR, cpu_regs_pkg::OP_BLK_SUB, cpu_regs_pkg::OP_LD_SPEC,
    cpu_regs_pkg::OP_ROT_ACC};
  logic [16:0]             carries = 17'b00001011011000101;
  logic [1:0]              flagExp [17] = '{2'h1, 2'h2, 2'h1, 2'h3, 2'h0, 2'h0, 2'h3, 2'h1,
    2'h0, 2'h2, 2'h1, 2'h2, 2'h3, 2'h1, 2'h3, 2'h1, 2'h0};

  cpu_register_array u_cpu_register_array (.clk(clk), .rst_n(rst_n), .pcOp(pcOp),
    .pcTarget(pcTarget), .pushByte(pushByte), .popByte(popByte), .spLoad(spLoad),
    .spValue(spValue), .idxFirstLoad(idxFirstLoad), .idxSecondLoad(idxSecondLoad),
    .idxValue(idxValue), .idxSelSecond(idxSelSecond), .displacement(displacement),
    .vectorPageLoad(vectorPageLoad), .sweepLoad(sweepLoad), .specValue(specValue),
    .vectorLow(vectorLow), .tableSecond(tableSecond), .fetchDone(fetchDone),
    .fetchState(fetchState), .fetchCycle(fetchCycle), .workWrite(workWrite),
    .workSel(workSel), .workValue(workValue), .aluWrite(aluWrite), .aluResult(aluResult),
    .flagOp(flagOp), .aluCarry(aluCarry), .aluFlags(aluFlags), .swapAccPair(swapAccPair),
    .swapMainSet(swapMainSet), .programCounter(programCounter), .stackPointer(stackPointer),
    .indexFirst(indexFirst), .indexSecond(indexSecond), .vectorPage(vectorPage),
    .sweepCount(sweepCount), .indexedAddr(indexedAddr), .tableAddr(tableAddr),
    .accumulator(accumulator), .statusBits(statusBits), .workRead(workRead),
    .testFlags(testFlags), .refreshAddr(refreshAddr), .refreshStrobe_n(refreshStrobe_n));

  fetch_model u_fetch_model (.clk(clk), .rst_n(rst_n), .go(go), .periphByte(periphByte),
    .fetchCycle(fetchCycle), .fetchState(fetchState), .fetchDone(fetchDone),
    .vectorLow(vectorLow));

  always #2 clk = ~clk;

  task results;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // cycle ceiling
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      fails = fails + 1;
      results();
    end
  end

  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares = compares + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task tk(input integer n);
    repeat (n) @(posedge clk);
  endtask

  task done(input string name);
    $display("test %s finished", name);
  endtask

  // one fetch: strobe pattern, refresh address, count step
  task fetch(input logic [7:0] sw);
    logic [4:0] seen;
    integer     k;
    tk(1); go <= 1'b1;
    tk(1); go <= 1'b0;
    for (k = 0; k < 5; k++)
    begin
      tk(1); #1 seen[k] = refreshStrobe_n;
      if (k == 2) check(refreshAddr, sw);
    end
    check(seen, 5'b10011);
    check(sweepCount, 8'(sw + 8'h1));
  endtask

  task wrw(input cpu_regs_pkg::work_sel_e s, input logic [7:0] v);
    tk(1); workWrite <= 1'b1; workSel <= s; workValue <= v;
    tk(1); workWrite <= 1'b0;
  endtask

  task rdw(input cpu_regs_pkg::work_sel_e s, input logic [7:0] e);
    tk(1); workSel <= s;
    tk(2); #1 check(workRead, e);
  endtask

  task swap(input logic accPair);
    tk(1); swapAccPair <= accPair; swapMainSet <= ~accPair;
    tk(1); swapAccPair <= 1'b0; swapMainSet <= 1'b0;
  endtask

  initial
  begin
    clk = 0; rst_n = 0; pushByte = 0; popByte = 0; spLoad = 0; idxFirstLoad = 0;
    idxSecondLoad = 0; idxSelSecond = 0; vectorPageLoad = 0; sweepLoad = 0; tableSecond = 0;
    workWrite = 0; aluWrite = 0; aluCarry = 0; swapAccPair = 0; swapMainSet = 0; go = 0;
    displacement = 0; specValue = 0; workValue = 0; aluResult = 0; aluFlags = 0;
    periphByte = 0; pcTarget = 0; spValue = 0; idxValue = 0; fails = 0; compares = 0;
    cycles = 0; pcOp = cpu_regs_pkg::PC_HOLD; workSel = cpu_regs_pkg::WR_B;
    flagOp = cpu_regs_pkg::OP_NONE;
    tk(10); rst_n <= 1'b1;
    #1 check(programCounter, 16'h0000);
    check(stackPointer, 16'hffff);
    check({sweepCount, statusBits}, 16'h0000);
    check(refreshStrobe_n, 1'b1);
    done("reset");
    tk(1); pcOp <= cpu_regs_pkg::PC_INC;
    tk(3); pcOp <= cpu_regs_pkg::PC_HOLD;
    #1 check(programCounter, 16'h0003);
    tk(1); pcOp <= cpu_regs_pkg::PC_LOAD; pcTarget <= 16'hfffe;
    tk(1); pcOp <= cpu_regs_pkg::PC_INC;
    #1 check(programCounter, 16'hfffe);
    tk(2); pcOp <= cpu_regs_pkg::PC_HOLD;
    #1 check(programCounter, 16'h0000);
    done("program counter");
    tk(1); pushByte <= 1'b1;
    tk(2); pushByte <= 1'b0; popByte <= 1'b1;
    #1 check(stackPointer, 16'hfffd);
    tk(1); popByte <= 1'b0; spLoad <= 1'b1; pushByte <= 1'b1;
    #1 check(stackPointer, 16'hfffe);
    tk(1); spLoad <= 1'b0; pushByte <= 1'b0; popByte <= 1'b1;
    #1 check(stackPointer, 16'h0000);
    tk(1); popByte <= 1'b0;
    #1 check(stackPointer, 16'h0001);
    done("stack pointer");
    tk(1); idxValue <= 16'h1000; idxFirstLoad <= 1'b1; displacement <= 8'hfe;
    tk(1); idxFirstLoad <= 1'b0; idxSecondLoad <= 1'b1; idxValue <= 16'hff90;
    tk(1); idxSecondLoad <= 1'b0;
    #1 check(indexedAddr, 16'h0ffe);
    check(indexSecond, 16'hff90);
    tk(1); idxSelSecond <= 1'b1; displacement <= 8'h7f;
    tk(2); #1 check(indexedAddr, 16'h000f);
    check(indexFirst, 16'h1000);
    done("index");
    tk(1); specValue <= 8'h12; vectorPageLoad <= 1'b1; periphByte <= 8'h35;
    tk(1); vectorPageLoad <= 1'b0;
    tk(1); #1 check(tableAddr, 16'h1234);
    check(vectorPage, 8'h12);
    tk(1); tableSecond <= 1'b1;
    tk(2); #1 check(tableAddr, 16'h1235);
    done("vector");
    fetch(8'h00);
    tk(1); specValue <= 8'hff; sweepLoad <= 1'b1;
    tk(1); sweepLoad <= 1'b0;
    #1 check(sweepCount, 8'hff);
    fetch(8'hff);
    done("sweep");
    for (i = 0; i < 6; i++)
      wrw(sels[i], 8'(8'h11 * (i + 1)));
    tk(1); aluWrite <= 1'b1; aluResult <= 8'h5a; workWrite <= 1'b1; workValue <= 8'h99;
    workSel <= cpu_regs_pkg::WR_ACC;
    tk(1); aluWrite <= 1'b0; workWrite <= 1'b0;
    #1 check(accumulator, 8'h5a);
    for (i = 0; i < 6; i++)
      rdw(sels[i], 8'(8'h11 * (i + 1)));
    swap(1'b0);
    rdw(cpu_regs_pkg::WR_B, 8'h00);
    check(accumulator, 8'h5a);
    swap(1'b0);
    rdw(cpu_regs_pkg::WR_L, 8'h66);
    done("working set");
    for (i = 0; i < 17; i++)
    begin
      tk(1); flagOp <= ops[i]; aluCarry <= carries[i];
      tk(1); flagOp <= cpu_regs_pkg::OP_NONE;
      #1 check(statusBits[1:0], flagExp[i]);
    end
    tk(1); flagOp <= cpu_regs_pkg::OP_ADD; aluCarry <= 1'b1; aluFlags <= 8'hff;
    tk(1); flagOp <= cpu_regs_pkg::OP_NONE; aluFlags <= 8'h00;
    #1 check(statusBits, 8'hd5);
    check(testFlags, 4'hf);
    swap(1'b1);
    #1 check({accumulator, statusBits}, 16'h0000);
    rdw(cpu_regs_pkg::WR_C, 8'h22);
    swap(1'b1);
    #1 check({accumulator, statusBits}, 16'h5ad5);
    tk(1); swapAccPair <= 1'b1;
    tk(2); swapAccPair <= 1'b0;
    #1 check({accumulator, statusBits}, 16'h5ad5);
    done("flags");
    results();
  end
endmodule

`default_nettype wire
